// ---- core/csor_pkg.sv ----
// csor_pkg: constants for the core status/option register block
// assumes: single core clock, registers reached over the core's file port
package csor_pkg;
  // ---------------------------------------------------------------
  // register addresses on the core file port (bank 0 / bank 1 view)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_OPTION = 8'h81;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0b;
  localparam logic [6:0] ADDR_LOW_MASK = 7'h7f;
  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int ST_INDIRECT = 7;
  localparam int ST_BANK_HIGH = 6;
  localparam int ST_BANK_SEL = 5;
  localparam int ST_GUARD_EXP = 4;
  localparam int ST_PWR_DN = 3;
  localparam int ST_ZERO = 2;
  localparam int ST_NIBBLE = 1;
  localparam int ST_CARRY = 0;
  // ---------------------------------------------------------------
  // option field positions
  // ---------------------------------------------------------------
  localparam int OP_PULLUP = 7;
  localparam int OP_EDGE = 6;
  localparam int OP_SRC = 5;
  localparam int OP_TEDGE = 4;
  localparam int OP_OWNER = 3;
  // ---------------------------------------------------------------
  // irq control field positions
  // ---------------------------------------------------------------
  localparam int IC_TICK_IF = 2;
  localparam int IC_EXT_IF = 1;
  localparam int IC_CHG_IF = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  // ---------------------------------------------------------------
  // alu flag-update classes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CSOR_FL_NONE,
    CSOR_FL_Z,
    CSOR_FL_ARITH,
    CSOR_FL_ROT_L,
    CSOR_FL_ROT_R
  } csor_flag_op_t;
endpackage

// ---- core/csor_regs.sv ----
// csor_regs: status, option and irq control registers of the core
// assumes: datapath presents one instruction result per core clock;
// timers, pin logic and sleep control sit outside and use the outputs
module csor_regs (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic clr_instr_i,
  input wire logic [7:0] rd_addr_i,
  input wire csor_pkg::csor_flag_op_t flag_op_i,
  input wire logic [7:0] alu_result_i,
  input wire logic alu_nibble_cy_i,
  input wire logic alu_carry_i,
  input wire logic [7:0] rot_src_i,
  input wire logic kick_guard_instr_i,
  input wire logic halt_instr_i,
  input wire logic guard_expired_i,
  input wire logic tick_overflow_i,
  input wire logic ext_irq_event_i,
  input wire logic pin_change_i,
  input wire logic [6:0] direct_addr_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] status_o,
  output logic [7:0] option_o,
  output logic [7:0] irq_ctrl_o,
  output logic [7:0] data_addr_o,
  output logic pullups_off_o,
  output logic ext_irq_rising_o,
  output logic tick_from_pin_o,
  output logic tick_on_fall_o,
  output logic prescale_to_guard_o,
  output logic [8:0] tick_div_o,
  output logic [7:0] guard_div_o
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // status and irq control are mirrored in both banks, option is not
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    if (r == csor_pkg::ADDR_OPTION) begin
      hit = (a == r);
    end else begin
      hit = (a[6:0] == r[6:0]);
    end
  endfunction

  // result-null test shared by logic and arithmetic updates
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // tick ratio is two to the power (rate + 1)
  function automatic logic [8:0] tick_ratio(input logic [2:0] rate);
    tick_ratio = 9'h002 << rate;
  endfunction

  // guard ratio is two to the power rate
  function automatic logic [7:0] guard_ratio(input logic [2:0] rate);
    guard_ratio = 8'h01 << rate;
  endfunction

  // flags the current operation produces; others pass through
  function automatic logic [2:0] alu_flags(
    input csor_pkg::csor_flag_op_t op,
    input logic [2:0] cur,
    input logic [7:0] res,
    input logic nib,
    input logic cy,
    input logic [7:0] src
  );
    alu_flags = cur;
    case (op)
      csor_pkg::CSOR_FL_Z: begin
        alu_flags[csor_pkg::ST_ZERO] = is_zero(res);
      end
      csor_pkg::CSOR_FL_ARITH: begin
        alu_flags[csor_pkg::ST_ZERO] = is_zero(res);
        alu_flags[csor_pkg::ST_NIBBLE] = nib;
        alu_flags[csor_pkg::ST_CARRY] = cy;
      end
      csor_pkg::CSOR_FL_ROT_L: begin
        alu_flags[csor_pkg::ST_CARRY] = src[7];
      end
      csor_pkg::CSOR_FL_ROT_R: begin
        alu_flags[csor_pkg::ST_CARRY] = src[0];
      end
      default: begin
      end
    endcase
  endfunction

  // {guard, power-down}; expiry is the hardware event and is applied
  // last, so it wins over a same-cycle kick or halt
  function automatic logic [1:0] cause_bits(
    input logic [1:0] cur,
    input logic kick,
    input logic halt,
    input logic expired
  );
    cause_bits = cur;
    if (kick) begin
      cause_bits = 2'b11;
    end
    if (halt) begin
      cause_bits = 2'b10;
    end
    if (expired) begin
      cause_bits[1] = 1'b0;
    end
  endfunction

  // read mux; unmapped addresses read as zero
  function automatic logic [7:0] read_mux(
    input logic [7:0] addr,
    input logic [7:0] st,
    input logic [7:0] opt,
    input logic [7:0] ic
  );
    read_mux = 8'h00;
    if (hit(addr, csor_pkg::ADDR_STATUS)) begin
      read_mux = st;
    end else if (hit(addr, csor_pkg::ADDR_OPTION)) begin
      read_mux = opt;
    end else if (hit(addr, csor_pkg::ADDR_IRQ_CTRL)) begin
      read_mux = ic;
    end
  endfunction

  // option bits that leave the block as controls, in port order
  function automatic logic [4:0] opt_ctl(input logic [7:0] o);
    opt_ctl = {o[csor_pkg::OP_PULLUP], o[csor_pkg::OP_EDGE],
      o[csor_pkg::OP_SRC], o[csor_pkg::OP_TEDGE], o[csor_pkg::OP_OWNER]};
  endfunction

  // ---------------------------------------------------------------
  // status register
  // ---------------------------------------------------------------
  logic [7:0] status_q, status_d;
  logic [7:0] option_q, option_d;
  logic [7:0] irq_ctrl_q, irq_ctrl_d;
  logic st_wr;
  logic flags_by_alu;
  logic take_wr_flags;
  logic [2:0] base_flags;

  always_comb begin
    status_d = status_q;
    st_wr = wr_en_i && hit(wr_addr_i, csor_pkg::ADDR_STATUS);
    flags_by_alu = (flag_op_i != csor_pkg::CSOR_FL_NONE);
    // a clear leaves the carry and nibble flags alone
    take_wr_flags = st_wr && !flags_by_alu && !clr_instr_i;
    if (st_wr) begin
      // bank bits only; guard and power-down are never written
      status_d[7:5] = wr_data_i[7:5];
    end
    base_flags = take_wr_flags ? wr_data_i[2:0] : status_q[2:0];
    status_d[2:0] = alu_flags(flag_op_i, base_flags, alu_result_i,
      alu_nibble_cy_i, alu_carry_i, rot_src_i);
    if (clr_instr_i && st_wr) begin
      status_d[7:5] = 3'h0;
      status_d[csor_pkg::ST_ZERO] = 1'b1;
    end
    status_d[4:3] = cause_bits(status_q[4:3], kick_guard_instr_i,
      halt_instr_i, guard_expired_i);
  end

  // ---------------------------------------------------------------
  // option and irq control registers
  // ---------------------------------------------------------------
  always_comb begin
    option_d = option_q;
    irq_ctrl_d = irq_ctrl_q;
    if (wr_en_i && hit(wr_addr_i, csor_pkg::ADDR_OPTION)) begin
      option_d = clr_instr_i ? 8'h00 : wr_data_i;
    end
    if (wr_en_i && hit(wr_addr_i, csor_pkg::ADDR_IRQ_CTRL)) begin
      irq_ctrl_d = clr_instr_i ? 8'h00 : wr_data_i;
    end
    // event sets win over a same-cycle software clear
    if (tick_overflow_i) begin
      irq_ctrl_d[csor_pkg::IC_TICK_IF] = 1'b1;
    end
    if (ext_irq_event_i) begin
      irq_ctrl_d[csor_pkg::IC_EXT_IF] = 1'b1;
    end
    if (pin_change_i) begin
      irq_ctrl_d[csor_pkg::IC_CHG_IF] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      status_q <= csor_pkg::STATUS_RST;
      option_q <= csor_pkg::OPTION_RST;
      irq_ctrl_q <= csor_pkg::IRQ_CTRL_RST;
    end else begin
      status_q <= status_d;
      option_q <= option_d;
      irq_ctrl_q <= irq_ctrl_d;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] rd_d;

  always_comb begin
    rd_d = read_mux(rd_addr_i, status_q, option_q, irq_ctrl_q);
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // register copies and direct data address
  // ---------------------------------------------------------------
  logic [7:0] addr_d;

  always_comb begin
    // the bank bit after this instruction steers the next access
    addr_d = {status_d[csor_pkg::ST_BANK_SEL], direct_addr_i};
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      status_o <= csor_pkg::STATUS_RST;
      option_o <= csor_pkg::OPTION_RST;
      irq_ctrl_o <= csor_pkg::IRQ_CTRL_RST;
      data_addr_o <= 8'h00;
    end else begin
      status_o <= status_d;
      option_o <= option_d;
      irq_ctrl_o <= irq_ctrl_d;
      data_addr_o <= addr_d;
    end
  end

  // ---------------------------------------------------------------
  // option controls and prescaler ratios
  // ---------------------------------------------------------------
  logic [4:0] ctl_d;
  logic [2:0] rate;
  logic [8:0] tdiv_d;
  logic [7:0] gdiv_d;

  always_comb begin
    ctl_d = opt_ctl(option_d);
    rate = option_d[2:0];
    tdiv_d = tick_ratio(rate);
    gdiv_d = guard_ratio(rate);
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pullups_off_o <= csor_pkg::OPTION_RST[csor_pkg::OP_PULLUP];
      ext_irq_rising_o <= csor_pkg::OPTION_RST[csor_pkg::OP_EDGE];
      tick_from_pin_o <= csor_pkg::OPTION_RST[csor_pkg::OP_SRC];
      tick_on_fall_o <= csor_pkg::OPTION_RST[csor_pkg::OP_TEDGE];
      prescale_to_guard_o <= csor_pkg::OPTION_RST[csor_pkg::OP_OWNER];
      tick_div_o <= tick_ratio(csor_pkg::OPTION_RST[2:0]);
      guard_div_o <= guard_ratio(csor_pkg::OPTION_RST[2:0]);
    end else begin
      pullups_off_o <= ctl_d[4];
      ext_irq_rising_o <= ctl_d[3];
      tick_from_pin_o <= ctl_d[2];
      tick_on_fall_o <= ctl_d[1];
      prescale_to_guard_o <= ctl_d[0];
      tick_div_o <= tdiv_d;
      guard_div_o <= gdiv_d;
    end
  end
endmodule

// ---- testbench/csor_regs_checker.sv ----
// csor_regs_checker: port assertions for the status/option block
// assumes: bound to csor_regs, one clock, sync active-low reset
module csor_regs_checker (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic wr_en_i,
  input wire logic clr_instr_i,
  input wire csor_pkg::csor_flag_op_t flag_op_i,
  input wire logic [7:0] alu_result_i,
  input wire logic alu_nibble_cy_i,
  input wire logic alu_carry_i,
  input wire logic [7:0] rot_src_i,
  input wire logic kick_guard_instr_i,
  input wire logic halt_instr_i,
  input wire logic guard_expired_i,
  input wire logic tick_overflow_i,
  input wire logic [6:0] direct_addr_i,
  input wire logic [7:0] status_o,
  input wire logic [7:0] option_o,
  input wire logic [7:0] irq_ctrl_o,
  input wire logic [7:0] data_addr_o,
  input wire logic [8:0] tick_div_o,
  input wire logic [7:0] guard_div_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire st_wr = wr_en_i && wr_addr_i[6:0] == 7'h03;
  sequence s_quiet;
    !kick_guard_instr_i && !halt_instr_i && !guard_expired_i;
  endsequence
  sequence s_halt;
    halt_instr_i && !kick_guard_instr_i && !guard_expired_i;
  endsequence
  a_arith_flags: assert property (flag_op_i == csor_pkg::CSOR_FL_ARITH
    |=> status_o[1:0] == $past({alu_nibble_cy_i, alu_carry_i}))
    else $error("arith flags wrong");
  a_zero_flag: assert property (!clr_instr_i && flag_op_i inside
    {csor_pkg::CSOR_FL_Z, csor_pkg::CSOR_FL_ARITH}
    |=> status_o[2] == $past(alu_result_i == 8'h00)) else $error("zero flag");
  a_guard_ro: assert property (st_wr ##0 s_quiet
    |=> $stable(status_o[4:3])) else $error("cause bits written");
  a_clear_status: assert property (st_wr && clr_instr_i
    |=> status_o[7:5] == 3'h0 && status_o[2]) else $error("clear wrong");
  a_bank_addr: assert property (nrst_i
    |=> data_addr_o == {status_o[5], $past(direct_addr_i)})
    else $error("bank address wrong");
  a_kick_sets: assert property (kick_guard_instr_i && !halt_instr_i
    && !guard_expired_i |=> status_o[4:3] == 2'b11) else $error("kick");
  a_halt_pd: assert property (s_halt |=> status_o[4:3] == 2'b10)
    else $error("halt");
  a_expiry_clr: assert property (guard_expired_i |=> !status_o[4])
    else $error("expiry");
  a_rot_carry: assert property (flag_op_i inside
    {csor_pkg::CSOR_FL_ROT_L, csor_pkg::CSOR_FL_ROT_R} |=> status_o[0] ==
    $past(flag_op_i == csor_pkg::CSOR_FL_ROT_L ? rot_src_i[7] : rot_src_i[0]))
    else $error("rotate carry");
  a_div_ratio: assert property ((tick_div_o == (9'h2 << option_o[2:0])) &&
    (guard_div_o == (8'h1 << option_o[2:0]))) else $error("divider");
  a_tick_flag: assert property (tick_overflow_i |=> irq_ctrl_o[2])
    else $error("tick flag");
endmodule
bind csor_regs csor_regs_checker i_chk (.*);

// ---- testbench/csor_alu_model.sv ----
// csor_alu_model: datapath adder feeding the flag inputs
// assumes: combinational; subtract adds the two's complement of b
module csor_alu_model (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic sub_i,
  output logic [7:0] res_o,
  output logic nib_o,
  output logic cy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] bx;
  logic [4:0] lo;
  assign bx = sub_i ? ~b_i : b_i;
  assign {cy_o, res_o} = {1'b0, a_i} + {1'b0, bx} + 9'(sub_i);
  assign lo = {1'b0, a_i[3:0]} + {1'b0, bx[3:0]} + 5'(sub_i);
  assign nib_o = lo[4];
endmodule

// ---- testbench/csor_regs_tb.sv ----
// csor_regs_tb: directed tests of the status/option block
// assumes: alu model drives the flag inputs, events are one-cycle pulses
module csor_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0;
  logic nrst = 0;
  logic we = 0;
  logic clr = 0;
  logic sub = 0;
  logic [7:0] wa = 0, wd = 0, ra = 0, a = 0, b = 0, src = 0;
  logic [6:0] da = 0;
  logic [5:0] ev = 0;
  csor_pkg::csor_flag_op_t fop = csor_pkg::CSOR_FL_NONE;
  logic [7:0] rd, st, opt, irq, dadr, res, gdiv;
  logic nib, cy;
  logic [8:0] tdiv;
  wire [4:0] ob;
  int bad_count = 0, checks_done = 0, cyc = 0;
  logic [7:0] ta [4] = '{8'h03, 8'h08, 8'hf0, 8'h05};
  logic [7:0] tb [4] = '{8'h05, 8'h08, 8'h10, 8'h03};
  logic [2:0] tx [4] = '{3'h0, 3'h2, 3'h5, 3'h3};
  csor_alu_model i_alu (.a_i(a), .b_i(b), .sub_i(sub), .res_o(res),
    .nib_o(nib), .cy_o(cy));
  csor_regs i_dut (.core_clk_i(clk), .nrst_i(nrst), .wr_addr_i(wa),
    .wr_data_i(wd), .wr_en_i(we), .clr_instr_i(clr), .rd_addr_i(ra),
    .flag_op_i(fop), .alu_result_i(res), .alu_nibble_cy_i(nib),
    .alu_carry_i(cy), .rot_src_i(src), .kick_guard_instr_i(ev[5]),
    .halt_instr_i(ev[4]), .guard_expired_i(ev[3]), .tick_overflow_i(ev[2]),
    .ext_irq_event_i(ev[1]), .pin_change_i(ev[0]), .direct_addr_i(da),
    .rd_data_o(rd), .status_o(st), .option_o(opt), .irq_ctrl_o(irq),
    .data_addr_o(dadr), .pullups_off_o(ob[4]), .ext_irq_rising_o(ob[3]),
    .tick_from_pin_o(ob[2]), .tick_on_fall_o(ob[1]),
    .prescale_to_guard_o(ob[0]), .tick_div_o(tdiv), .guard_div_o(gdiv));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one instruction, then an idle cycle
  task automatic op(input logic [7:0] ad, input logic [7:0] dt,
    input logic w, input logic c, input logic [5:0] e,
    input csor_pkg::csor_flag_op_t f = csor_pkg::CSOR_FL_NONE);
    wa = ad; wd = dt; we = w; clr = c; ev = e; fop = f;
    step();
    we = 0; clr = 0; ev = 0; fop = csor_pkg::CSOR_FL_NONE;
    step();
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 nrst = 1;
    chk(st, 8'h18);
    chk(tdiv, 9'h100);
    chk(gdiv, 8'h80);
    op(8'h03, 8'h3f, 1, 0, 0);
    chk(st, 8'h3f);
    op(8'h00, 8'h00, 0, 0, 6'h10);
    chk(st, 8'h37);
    op(8'h83, 8'h08, 1, 0, 0);
    chk(st, 8'h10);
    da = 7'h12;
    op(8'h03, 8'h20, 1, 0, 0);
    chk(dadr, 8'h92);
    op(8'h03, 8'h00, 1, 0, 0);
    chk(dadr, 8'h12);
    for (int i = 0; i < 4; i++) begin
      a = ta[i]; b = tb[i]; sub = (i == 0 || i == 3);
      op(8'h03, 8'h3f, 1, 0, 0, csor_pkg::CSOR_FL_ARITH);
      chk(st, {5'h06, tx[i]});
    end
    op(8'h03, 8'h00, 1, 1, 0);
    chk(st, 8'h17);
    op(8'h00, 8'h00, 0, 0, 6'h20);
    chk(st, 8'h1f);
    op(8'h00, 8'h00, 0, 0, 6'h08);
    chk(st, 8'h0f);
    op(8'h00, 8'h00, 0, 0, 6'h10);
    chk(st, 8'h17);
    src = 8'h80;
    op(8'h00, 8'h00, 0, 0, 0, csor_pkg::CSOR_FL_ROT_R);
    chk(st, 8'h16);
    op(8'h00, 8'h00, 0, 0, 0, csor_pkg::CSOR_FL_ROT_L);
    chk(st, 8'h17);
    ra = 8'h81;
    for (int r = 0; r < 8; r++) begin
      op(8'h81, {(r[0] ? 5'h15 : 5'h0a), r[2:0]}, 1, 0, 0);
      chk(ob, r[0] ? 5'h15 : 5'h0a);
      chk(opt, {(r[0] ? 5'h15 : 5'h0a), r[2:0]});
      chk(tdiv, 9'h2 << r);
      chk(gdiv, 9'(8'h1 << r));
      chk(rd, {(r[0] ? 5'h15 : 5'h0a), r[2:0]});
    end
    ra = 8'h0b;
    op(8'h0b, 8'h00, 1, 0, 6'h07);
    chk(irq, 8'h07);
    chk(rd, 8'h07);
    op(8'h0b, 8'h00, 1, 0, 0);
    chk(irq, 8'h00);
    op(8'h8b, 8'h80, 1, 0, 6'h04);
    chk(irq, 8'h84);
    finish_test();
  end
endmodule
